// file: logic/acmcr_pkg.sv
// Package of constants and types for the converter mode control register.
package acmcr_pkg;

   // ------------------------------------------------------------
   // Register selection and layout
   // ------------------------------------------------------------
   localparam logic [2:0] ACMCR_SEL_MODE = 3'h1;
   localparam int ACMCR_WIDTH = 24;
   localparam logic [23:0] ACMCR_RESET = 24'h080060;
   localparam int ACMCR_MODE_LSB = 21;
   localparam int ACMCR_APPEND_BIT = 20;
   localparam int ACMCR_CLK_LSB = 18;
   localparam int ACMCR_FILTER_BIT = 15;
   localparam int ACMCR_PARITY_BIT = 13;
   localparam int ACMCR_SINGLE_BIT = 11;
   localparam int ACMCR_REJECT_BIT = 10;
   localparam int ACMCR_DIV_LSB = 0;
   // Bits 17, 16, 14 and 12 always read as zero.
   localparam logic [23:0] ACMCR_WRITE_MASK = 24'hfcafff;
   localparam int ACMCR_RESTART_CYCLES = 2;
   localparam logic [4:0] ACMCR_BITS_LAST = 5'h17;

   // ------------------------------------------------------------
   // Clock source encodings
   // ------------------------------------------------------------
   localparam logic [1:0] ACMCR_CLK_XTAL = 2'h0;
   localparam logic [1:0] ACMCR_CLK_EXT = 2'h1;
   localparam logic [1:0] ACMCR_CLK_INT = 2'h2;
   localparam logic [1:0] ACMCR_CLK_INT_OUT = 2'h3;

   typedef struct packed {
      logic [2:0] operating_mode_select;
      logic append_status;
      logic [1:0] clock_source_select;
      logic filter_order_select;
      logic parity_enable;
      logic single_cycle;
      logic sixty_hz_reject;
      logic [9:0] output_rate_divider;
   } acmcr_fields_t;

   typedef struct packed {
      logic use_crystal;
      logic use_external;
      logic use_internal;
      logic clock_pin_b_oe;
   } acmcr_clk_t;

endpackage : acmcr_pkg

// file: logic/acmcr_clk_decode.sv
// Decode of the clock-source select field into clock routing controls.
`timescale 1ns/100ps
module acmcr_clk_decode (
   input wire logic [1:0] clock_source_select,
   output acmcr_pkg::acmcr_clk_t clk_ctl
);
   import acmcr_pkg::*;

   always_comb begin
      clk_ctl = '0;
      unique case (clock_source_select)
         ACMCR_CLK_XTAL: clk_ctl.use_crystal = 1'b1;
         ACMCR_CLK_EXT: clk_ctl.use_external = 1'b1;
         ACMCR_CLK_INT: clk_ctl.use_internal = 1'b1;
         ACMCR_CLK_INT_OUT: begin
            clk_ctl.use_internal = 1'b1;
            clk_ctl.clock_pin_b_oe = 1'b1;
         end
      endcase
   end

endmodule : acmcr_clk_decode

// file: logic/acmcr_top.sv
// Converter mode control register with serial access and derived controls.
`timescale 1ns/100ps
module acmcr_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic [2:0] register_select,
   input wire logic access_write,
   input wire logic [23:0] data_word,
   output logic dout,
   output logic restart,
   output logic not_ready_set,
   output logic parity_flag,
   output acmcr_pkg::acmcr_fields_t mode_fields,
   output acmcr_pkg::acmcr_clk_t clk_ctl
);
   import acmcr_pkg::*;

   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   // Reset leaves through two flops so every register comes out of reset on the same edge.
   logic [1:0] rst_sync_r;
   logic rst_n;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) rst_sync_r <= 2'b00;
      else rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // The flops reset to the idle pin levels so that no false sclk edge follows reset.
   logic [2:0] pin_s1_r, pin_s2_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 3'h2;
         pin_s2_r <= 3'h2;
      end else begin
         pin_s1_r <= {sclk, cs_n, din};
         pin_s2_r <= pin_s1_r;
      end
   end

   function automatic logic odd_ones(input logic [23:0] w);
      odd_ones = ^w;
   endfunction : odd_ones

   // ------------------------------------------------------------
   // Serial shifter and register
   // ------------------------------------------------------------
   logic sclk_d_r, sclk_d_nxt;
   logic [23:0] mode_r, mode_nxt;
   logic [23:0] shift_r, shift_nxt;
   logic [4:0] count_r, count_nxt;
   logic active_r, active_nxt;
   logic dout_r, dout_nxt;
   logic [1:0] restart_cnt_r, restart_cnt_nxt;
   logic restart_r, restart_nxt;
   logic nrdy_r, nrdy_nxt;
   logic parity_r, parity_nxt;
   logic sel_mode;
   logic rise, fall, cs_active;
   logic write_done;

   assign sel_mode = (register_select == ACMCR_SEL_MODE);
   assign cs_active = !pin_s2_r[1];
   assign rise = pin_s2_r[2] && !sclk_d_r;
   assign fall = !pin_s2_r[2] && sclk_d_r;

   always_comb begin
      sclk_d_nxt = pin_s2_r[2];
      mode_nxt = mode_r;
      shift_nxt = shift_r;
      count_nxt = count_r;
      active_nxt = active_r;
      dout_nxt = dout_r;
      write_done = 1'b0;
      if (!cs_active || !sel_mode) begin
         active_nxt = 1'b0;
         count_nxt = '0;
      end else if (!active_r) begin
         active_nxt = 1'b1;
         count_nxt = '0;
         shift_nxt = mode_r;
         dout_nxt = mode_r[23];
      end else if (rise) begin
         shift_nxt = {shift_r[22:0], pin_s2_r[0]};
         if (count_r == ACMCR_BITS_LAST) begin
            count_nxt = '0;
            if (access_write) begin
               // Reserved positions are forced low so they read back zero.
               mode_nxt = {shift_r[22:0], pin_s2_r[0]} & ACMCR_WRITE_MASK;
               write_done = 1'b1;
            end
         end else begin
            count_nxt = count_r + 5'h1;
         end
      end else if (fall && !access_write) begin
         dout_nxt = shift_r[23];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_r <= 1'b0;
         mode_r <= ACMCR_RESET;
         shift_r <= '0;
         count_r <= '0;
         active_r <= 1'b0;
         dout_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_d_nxt;
         mode_r <= mode_nxt;
         shift_r <= shift_nxt;
         count_r <= count_nxt;
         active_r <= active_nxt;
         dout_r <= dout_nxt;
      end
   end

   // ------------------------------------------------------------
   // Restart pulse
   // ------------------------------------------------------------
   always_comb begin
      restart_cnt_nxt = restart_cnt_r;
      restart_nxt = 1'b0;
      nrdy_nxt = 1'b0;
      if (restart_cnt_r != 2'h0) begin
         restart_cnt_nxt = restart_cnt_r - 2'h1;
         restart_nxt = 1'b1;
         nrdy_nxt = 1'b1;
      end
      // A write that lands during a running pulse starts the count again, so the set wins.
      if (write_done) begin
         restart_cnt_nxt = 2'(ACMCR_RESTART_CYCLES);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         restart_cnt_r <= '0;
         restart_r <= 1'b0;
         nrdy_r <= 1'b0;
      end else begin
         restart_cnt_r <= restart_cnt_nxt;
         restart_r <= restart_nxt;
         nrdy_r <= nrdy_nxt;
      end
   end

   // ------------------------------------------------------------
   // Parity flag
   // ------------------------------------------------------------
   always_comb begin
      // The flag follows the data word only while parity checking is enabled.
      if (mode_r[ACMCR_PARITY_BIT]) begin
         parity_nxt = odd_ones(data_word);
      end else begin
         parity_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) parity_r <= 1'b0;
      else parity_r <= parity_nxt;
   end

   // ------------------------------------------------------------
   // Field outputs
   // ------------------------------------------------------------
   acmcr_fields_t fields_r, fields_nxt;
   acmcr_clk_t clk_dec, clk_ctl_r;

   always_comb begin
      fields_nxt.operating_mode_select = mode_r[ACMCR_MODE_LSB +: 3];
      fields_nxt.append_status = mode_r[ACMCR_APPEND_BIT];
      fields_nxt.clock_source_select = mode_r[ACMCR_CLK_LSB +: 2];
      fields_nxt.filter_order_select = mode_r[ACMCR_FILTER_BIT];
      fields_nxt.parity_enable = mode_r[ACMCR_PARITY_BIT];
      fields_nxt.single_cycle = mode_r[ACMCR_SINGLE_BIT];
      fields_nxt.sixty_hz_reject = mode_r[ACMCR_REJECT_BIT];
      fields_nxt.output_rate_divider = mode_r[ACMCR_DIV_LSB +: 10];
   end

   acmcr_clk_decode u_clk_decode (
      .clock_source_select(mode_r[ACMCR_CLK_LSB +: 2]),
      .clk_ctl(clk_dec)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fields_r <= acmcr_fields_t'({ACMCR_RESET[23:18], ACMCR_RESET[15], ACMCR_RESET[13],
            ACMCR_RESET[11:0]});
         clk_ctl_r <= '0;
      end else begin
         fields_r <= fields_nxt;
         clk_ctl_r <= clk_dec;
      end
   end

   assign dout = dout_r;
   assign restart = restart_r;
   assign not_ready_set = nrdy_r;
   assign parity_flag = parity_r;
   assign mode_fields = fields_r;
   assign clk_ctl = clk_ctl_r;

endmodule : acmcr_top

// file: verification/acmcr_chk.sv
// Port checker for the converter mode control register.
`timescale 1ns/100ps
module acmcr_chk
   import acmcr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [2:0] register_select,
   input wire logic access_write,
   input wire logic [23:0] data_word,
   input wire logic dout,
   input wire logic restart,
   input wire logic not_ready_set,
   input wire logic parity_flag,
   input wire acmcr_pkg::acmcr_fields_t mode_fields,
   input wire acmcr_pkg::acmcr_clk_t clk_ctl
);
   logic [2:0] up_r;
   logic [1:0] sel;
   assign sel = mode_fields.clock_source_select;
   // The internal reset lags reset_n by two flops, so early checks wait.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) up_r <= 3'h0;
      else if (up_r != 3'h7) up_r <= up_r + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_RESET_FIELDS: assert property (up_r < 3'h3 |-> mode_fields == {ACMCR_RESET[23:18],
      ACMCR_RESET[15], ACMCR_RESET[13], ACMCR_RESET[11:0]}) else $error("bad reset fields");
   AST_PULSE_TWO: assert property ($rose(restart) |=> restart ##1 !restart)
      else $error("restart not two cycles");
   AST_NOT_READY: assert property (not_ready_set == restart) else $error("not ready apart");
   AST_IDLE_QUIET: assert property (cs_n [*8] |-> !restart && $stable(mode_fields))
      else $error("change while idle");
   AST_SELECTED: assert property ($rose(restart) |-> access_write && register_select == 3'h1)
      else $error("restart without write");
   AST_CLK_DECODE: assert property ((up_r == 3'h7 && $stable(sel)) [*3] |->
      clk_ctl == {sel == 2'h0, sel == 2'h1, sel[1], sel == 2'h3}) else $error("clock decode");
   AST_PARITY: assert property (($stable(mode_fields) && $stable(data_word)) [*2] |->
      parity_flag == (mode_fields.parity_enable & ^data_word)) else $error("parity");
   AST_DOUT_HOLD: assert property ((sclk && !cs_n) [*4] |-> $stable(dout))
      else $error("dout moved in high phase");
endmodule : acmcr_chk
bind acmcr_top acmcr_chk chk (.clk, .reset_n, .sclk, .cs_n, .register_select, .access_write,
   .data_word, .dout, .restart, .not_ready_set, .parity_flag, .mode_fields, .clk_ctl);

// file: verification/acmcr_host.sv
// Host model for the four-wire serial port.
`timescale 1ns/100ps
module acmcr_host (
   input wire logic clk,
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end
   // Six clocks a phase leaves margin over the three that the synchroniser needs.
   task automatic xfer(input int nb, input logic [23:0] wd, output logic [23:0] rd);
      cs_n <= 1'b0;
      for (int i = 23; i > 23 - nb; i--) begin
         repeat (6) @(posedge clk);
         rd[i] = dout;
         din <= wd[i];
         sclk <= 1'b1;
         repeat (6) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (8) @(posedge clk);
      cs_n <= 1'b1;
      din <= ~din;
      repeat (8) @(posedge clk);
   endtask : xfer
endmodule : acmcr_host

// file: verification/tb_acmcr_top.sv
// Self-checking bench for the converter mode control register.
`timescale 1ns/100ps
module tb_acmcr_top;
   import acmcr_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic access_write = 1'b0;
   logic sclk, cs_n, din, dout, restart, not_ready_set, parity_flag, ok;
   logic [2:0] register_select = 3'h1;
   logic [23:0] data_word = 24'h0;
   logic [23:0] exp_reg = 24'h080060;
   logic [23:0] rd, wd;
   logic [31:0] seed = 32'h9b8deb77;
   acmcr_fields_t mode_fields;
   acmcr_clk_t clk_ctl;
   int n_errors = 0;
   int total_checks = 0;
   int pulses = 0;
   int nrdy_pulses = 0;
   int p0, q0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (restart === 1'b1) pulses <= pulses + 1;
      if (not_ready_set === 1'b1) nrdy_pulses <= nrdy_pulses + 1;
   end
   acmcr_top uut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .register_select(register_select), .access_write(access_write), .data_word(data_word),
      .dout(dout), .restart(restart), .not_ready_set(not_ready_set),
      .parity_flag(parity_flag), .mode_fields(mode_fields), .clk_ctl(clk_ctl));
   acmcr_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   function automatic logic [23:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[23:0];
   endfunction : rnd
   task automatic check(input string nm, input logic [23:0] e, input logic [23:0] s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic print_verdict();
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      host.xfer(24, 24'h0, rd);
      check("reset read", 24'h080060, rd);
      for (int k = 0; k < 12; k++) begin
         wd = rnd();
         wd[19:18] = k[1:0];
         wd[17:16] = 2'h0;
         ok = (k % 4 != 3) && (k % 5 != 4);
         data_word <= rnd();
         register_select <= (k % 4 == 3) ? 3'h2 : 3'h1;
         access_write <= 1'b1;
         p0 = pulses;
         q0 = nrdy_pulses;
         host.xfer((k % 5 == 4) ? 10 : 24, wd, rd);
         if (ok) exp_reg = wd & 24'hfcafff;
         check("restart cycles", ok ? 24'h2 : 24'h0, 24'(pulses - p0));
         check("not ready cycles", ok ? 24'h2 : 24'h0, 24'(nrdy_pulses - q0));
         access_write <= 1'b0;
         register_select <= 3'h1;
         host.xfer(24, 24'h0, rd);
         check("readback", exp_reg, rd);
         check("fields", 24'({exp_reg[23:18], exp_reg[15], exp_reg[13], exp_reg[11:0]}),
            24'(mode_fields));
         check("parity", 24'(exp_reg[13] & ^data_word), 24'(parity_flag));
         check("clock", 24'({exp_reg[19:18] == 2'h0, exp_reg[19:18] == 2'h1, exp_reg[19],
            exp_reg[19:18] == 2'h3}), 24'(clk_ctl));
      end
      print_verdict();
   end
endmodule : tb_acmcr_top
